// *** logic/mbw_watchdog.sv ***
// Board supervisory watchdog: arms after firmware load, trips on missing refresh.
// Assumes REFRESH comes from on-chip firmware logic on CORE_CLK; NRST is the host reset.
// Function
// - Disarmed until firmware load delay ends
// - Armed: timeout after 10 ms without refresh
// - Timeout latches board reset until NRST
// - Trip holds all axis modules in reset
// - Trip disables analog and step drive outputs
// - Trip turns off green run indicator
`timescale 1ns/100ps
`include "mbw_cfg.svh"

module mbw_watchdog #(
  parameter logic [`MBW_CNT_W-1:0] ARM_CYCLES = `MBW_ARM_CYCLES,
  parameter logic [`MBW_CNT_W-1:0] TIMEOUT_CYCLES = `MBW_TIMEOUT_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  input wire logic REFRESH,
  output mbw_pkg::mbw_out_t STATUS
);
  import mbw_pkg::*;

  // ****************************************
  // State and timer
  // ****************************************
  mbw_state_t state;
  mbw_state_t next_state;
  logic [`MBW_CNT_W-1:0] count;
  logic [`MBW_CNT_W-1:0] next_count;
  mbw_out_t next_status;

  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      MBW_ST_LOAD:
      begin
        if (count >= ARM_CYCLES - 32'h1)
        begin
          next_state = MBW_ST_ARMED;
          next_count = '0;
        end
        else
        begin
          next_count = count + 32'h1;
        end
      end
      MBW_ST_ARMED:
      begin
        if (REFRESH)
        begin
          next_count = '0;
        end
        else if (count >= TIMEOUT_CYCLES - 32'h1)
        begin
          next_state = MBW_ST_TRIP;
        end
        else
        begin
          next_count = count + 32'h1;
        end
      end
      // No exit: only NRST leaves the trip state
      MBW_ST_TRIP:
      begin
        next_state = MBW_ST_TRIP;
      end
      default:
      begin
        next_state = MBW_ST_TRIP;
      end
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    next_status.armed = (next_state == MBW_ST_ARMED);
    next_status.tripped = (next_state == MBW_ST_TRIP);
    // Drives stay off until armed too, so a hung load cannot move a motor
    next_status.axis_rst_n = {`MBW_AXES{next_state != MBW_ST_TRIP}};
    next_status.analog_en = {`MBW_AXES{next_state == MBW_ST_ARMED}};
    next_status.step_en = {`MBW_AXES{next_state == MBW_ST_ARMED}};
    next_status.run_led = (next_state != MBW_ST_TRIP);
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state <= MBW_ST_LOAD;
      count <= '0;
      STATUS <= '{axis_rst_n: {`MBW_AXES{1'b1}}, analog_en: '0, step_en: '0, run_led: 1'b1,
                  armed: 1'b0, tripped: 1'b0};
    end
    else if (CLK_EN)
    begin
      state <= next_state;
      count <= next_count;
      STATUS <= next_status;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_arm_wait;
    @(posedge CORE_CLK) disable iff (!NRST)
    (state == MBW_ST_LOAD) |-> !STATUS.armed;
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("armed during load");

  property p_timeout;
    @(posedge CORE_CLK) disable iff (!NRST)
    (state == MBW_ST_ARMED && !REFRESH && CLK_EN && count == TIMEOUT_CYCLES - 32'h1)
      |=> (state == MBW_ST_TRIP);
  endproperty
  a_timeout: assert property (p_timeout) else $error("missed timeout");

  property p_latch;
    @(posedge CORE_CLK) disable iff (!NRST)
    (state == MBW_ST_TRIP) |=> (state == MBW_ST_TRIP);
  endproperty
  a_latch: assert property (p_latch) else $error("trip released");

  property p_axis_rst;
    @(posedge CORE_CLK) disable iff (!NRST)
    $past(state == MBW_ST_TRIP) && $past(CLK_EN) |-> (STATUS.axis_rst_n == '0);
  endproperty
  a_axis_rst: assert property (p_axis_rst) else $error("axis out of reset");

  property p_drive_off;
    @(posedge CORE_CLK) disable iff (!NRST)
    STATUS.tripped |-> (STATUS.analog_en == '0 && STATUS.step_en == '0);
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive on while tripped");

  property p_led;
    @(posedge CORE_CLK) disable iff (!NRST)
    STATUS.tripped |-> !STATUS.run_led;
  endproperty
  a_led: assert property (p_led) else $error("run led on while tripped");

  property p_no_self_clear;
    @(posedge CORE_CLK) disable iff (!NRST)
    STATUS.tripped |=> STATUS.tripped;
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("trip cleared without reset");

  property p_refresh;
    @(posedge CORE_CLK) disable iff (!NRST)
    (state == MBW_ST_ARMED && REFRESH && CLK_EN) |=> (count == '0 && state == MBW_ST_ARMED);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh did not restart timer");

  // ****************************************
  // Checker helper
  // ****************************************
  // Counts enabled edges since release on its own, so the arming check
  // does not lean on the timer that it judges
  logic [`MBW_CNT_W-1:0] since_release;
  logic [`MBW_CNT_W-1:0] next_since_release;

  always_comb
  begin
    next_since_release = since_release;
    if (since_release != '1)
    begin
      next_since_release = since_release + 32'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      since_release <= '0;
    end
    else if (CLK_EN)
    begin
      since_release <= next_since_release;
    end
  end

  property p_arm_time;
    @(posedge CORE_CLK) disable iff (!NRST)
    $rose(STATUS.armed) |-> (since_release == ARM_CYCLES);
  endproperty
  a_arm_time: assert property (p_arm_time) else $error("armed at wrong time");

  property p_load_holds;
    @(posedge CORE_CLK) disable iff (!NRST)
    (state == MBW_ST_LOAD && CLK_EN && count < ARM_CYCLES - 32'h1) |=> (state == MBW_ST_LOAD);
  endproperty
  a_load_holds: assert property (p_load_holds) else $error("left load too early");

  property p_no_early_trip;
    @(posedge CORE_CLK) disable iff (!NRST)
    (state == MBW_ST_ARMED && CLK_EN && count < TIMEOUT_CYCLES - 32'h1) |=> (state == MBW_ST_ARMED);
  endproperty
  a_no_early_trip: assert property (p_no_early_trip) else $error("tripped before timeout");

  property p_axis_free;
    @(posedge CORE_CLK) disable iff (!NRST)
    !STATUS.tripped |-> (STATUS.axis_rst_n == '1);
  endproperty
  a_axis_free: assert property (p_axis_free) else $error("axis held in reset without trip");

  property p_led_on;
    @(posedge CORE_CLK) disable iff (!NRST)
    !STATUS.tripped |-> STATUS.run_led;
  endproperty
  a_led_on: assert property (p_led_on) else $error("run led off without trip");

  // Clock enable low must freeze timer, state and outputs alike
  property p_freeze;
    @(posedge CORE_CLK) disable iff (!NRST)
    !CLK_EN |=> ($stable(state) && $stable(count) && $stable(STATUS));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  c_arm: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(STATUS.armed));
  c_trip: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(STATUS.tripped));
  c_refresh: cover property (@(posedge CORE_CLK) disable iff (!NRST) STATUS.armed && REFRESH);
  c_freeze: cover property (@(posedge CORE_CLK) disable iff (!NRST) STATUS.armed && !CLK_EN);

endmodule // mbw_watchdog

// *** logic/mbw_cfg.svh ***
// Timing constants and widths for the motion board watchdog.
// Assumes CORE_CLK at 25 MHz; included by the package and the top module.
`ifndef MBW_CFG_SVH
`define MBW_CFG_SVH

`define MBW_CLK_HZ 25000000
// Firmware load delay before arming, in milliseconds
`define MBW_ARM_DELAY_MS 3000
// Refresh timeout, in milliseconds
`define MBW_TIMEOUT_MS 10
// Cycle counts: clock in kHz, rounded down, times the milliseconds
`define MBW_ARM_CYCLES ((`MBW_CLK_HZ / 1000) * `MBW_ARM_DELAY_MS)
`define MBW_TIMEOUT_CYCLES ((`MBW_CLK_HZ / 1000) * `MBW_TIMEOUT_MS)
`define MBW_CNT_W 32
`define MBW_AXES 8

`endif

// *** logic/mbw_pkg.sv ***
// Types shared by the motion board watchdog.
// Assumes mbw_cfg.svh supplies widths.
`include "mbw_cfg.svh"

package mbw_pkg;

  typedef enum logic [2:0] {
    MBW_ST_LOAD = 3'h1,
    MBW_ST_ARMED = 3'h2,
    MBW_ST_TRIP = 3'h4
  } mbw_state_t;

  typedef struct packed {
    logic [`MBW_AXES-1:0] axis_rst_n;
    logic [`MBW_AXES-1:0] analog_en;
    logic [`MBW_AXES-1:0] step_en;
    logic run_led;
    logic armed;
    logic tripped;
  } mbw_out_t;

endpackage

// *** verif/mbw_fw_model.sv ***
// Firmware refresh source for the watchdog.
// Assumes CORE_CLK of the watchdog; RUN high means firmware is healthy.
`timescale 1ns/100ps

module mbw_fw_model #(
  parameter int PERIOD = 5
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic RUN,
  output logic REFRESH
);
  int cnt;

  // One-cycle strobe well inside the timeout
  always @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cnt <= 0;
      REFRESH <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      REFRESH <= RUN && (cnt == PERIOD - 1);
    end
  end
endmodule // mbw_fw_model

// *** verif/mbw_watchdog_bench.sv ***
// Self-checking bench for the watchdog.
// Assumes short arm and timeout counts; the model supplies refresh.
`timescale 1ns/100ps

module mbw_watchdog_bench;
  import mbw_pkg::*;
  localparam int ARM = 20;
  localparam int TMO = 10;
  logic CORE_CLK = 1'b0;
  logic NRST = 1'b0;
  logic CLK_EN = 1'b1;
  logic fw_run = 1'b0;
  logic REFRESH;
  mbw_out_t STATUS;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  mbw_fw_model i_fw (.CORE_CLK(CORE_CLK), .NRST(NRST), .RUN(fw_run), .REFRESH(REFRESH));
  mbw_watchdog #(.ARM_CYCLES(32'(ARM)), .TIMEOUT_CYCLES(32'(TMO))) i_dut (.CORE_CLK(CORE_CLK),
    .NRST(NRST), .CLK_EN(CLK_EN), .REFRESH(REFRESH), .STATUS(STATUS));

  initial forever #20 CORE_CLK = ~CORE_CLK;

  // ****************
  // Shared tasks
  // ****************
  task automatic check(input logic [26:0] seen, input logic [26:0] exp);
    comparisons++;
    if (seen !== exp)
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    if (seen !== exp)
      miscompares++;
  endtask

  // Sample 1 ns after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic t_arm_timeout;
    check(STATUS, {8'hFF, 16'h0000, 3'h4});
    @(posedge CORE_CLK) NRST <= 1'b1;
    tick(ARM - 1);
    check(STATUS.armed, 1'b0);
    tick(1);
    check({STATUS.armed, STATUS.step_en, STATUS.analog_en}, {1'b1, 16'hFFFF});
    tick(TMO - 1);
    check(STATUS.tripped, 1'b0);
    tick(1);
    check({STATUS.tripped, STATUS.run_led}, 2'h2);
  endtask

  // Healthy firmware afterwards must not undo the trip
  task automatic t_trip_latch;
    @(posedge CORE_CLK) fw_run <= 1'b1;
    tick(30);
    check({STATUS.axis_rst_n, STATUS.analog_en, STATUS.step_en, STATUS.run_led, STATUS.tripped},
      {24'h000000, 2'h1});
    @(posedge CORE_CLK) NRST <= 1'b0;
    tick(1);
    check(STATUS, {8'hFF, 16'h0000, 3'h4});
  endtask

  task automatic t_refresh_holds;
    @(posedge CORE_CLK) NRST <= 1'b1;
    tick(ARM + 50);
    check({STATUS.armed, STATUS.tripped}, 2'h2);
    @(posedge CORE_CLK)
    begin
      fw_run <= 1'b0;
      CLK_EN <= 1'b0;
    end
    tick(30);
    check(STATUS.tripped, 1'b0);
    @(posedge CORE_CLK) CLK_EN <= 1'b1;
    // Last refresh left the timer at 0..4, so the trip needs 6..10 enabled edges
    tick(5);
    check(STATUS.tripped, 1'b0);
    tick(TMO + 1);
    check(STATUS.tripped, 1'b1);
  endtask

  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  initial
  begin
    tick(11);
    t_arm_timeout;
    t_trip_latch;
    t_refresh_holds;
    give_verdict;
  end
endmodule // mbw_watchdog_bench
